/* rtl/cfg_loader_cfg.svh */
`ifndef CFG_LOADER_CFG_SVH
`define CFG_LOADER_CFG_SVH

// Configuration word addresses, in load order.
`define WA_P2_LINK   8'h44
`define WA_PM_CAP0   8'h50
`define WA_PM_DATA0  8'h51
`define WA_PM_CAP1   8'h52
`define WA_PM_DATA1  8'h53
`define WA_PM_CAP2   8'h54
`define WA_PM_DATA2  8'h55
`define WA_P0_MISC   8'h60
`define WORD_COUNT   4'h8

// Configuration dword byte offsets within one port.
`define OFS_LDR_CTRL 9'h000
`define OFS_PM_CAP   9'h040
`define OFS_PM_CSR   9'h044
`define OFS_LINK     9'h078
`define OFS_PHY_CNT  9'h08C
`define OFS_PORT_NUM 9'h0CC
`define OFS_SLOT     9'h0D0
`define OFS_LPVC     9'h144
`define OFS_VC0_MAP  9'h154
`define LDR_PORT     2'h3

// Source bit positions inside the loaded words.
`define SRC_CMPL     13
`define SRC_DSEL     14
`define SRC_NSR      0
`define SRC_AUX      1
`define SRC_D1       4
`define SRC_D2       5
`define SRC_PME      6
`define SRC_PMDATA   8
`define SRC_SLOT     1
`define SRC_DSI      2
`define SRC_LPVC     3
`define SRC_PNUM     4
`define SRC_TCMAP    9

// Destination bit positions inside the configuration dwords.
`define DST_CMPL     11
`define DST_DSEL     8
`define DST_NSR      3
`define DST_AUX      22
`define DST_D1       25
`define DST_D2       26
`define DST_PME      28
`define DST_PMDATA   24
`define DST_SLOT     28
`define DST_DSI      21
`define DST_LPVC     4
`define DST_PNUM     24
`define DST_TCMAP    1

// Loader control and status bits.
`define LDR_RELOAD   0
`define LDR_BUSY     0
`define LDR_LOADED   1

`endif

/* rtl/cfg_loader_pkg.sv */
package cfg_loader_pkg;

  // Loaded fields of one port, all reset to zero.
  typedef struct packed {
    logic       compliance;
    logic [1:0] data_change_count_select;
    logic       no_soft_reset;
    logic [2:0] aux_current;
    logic       d1_support;
    logic       d2_support;
    logic [1:0] pme_support;
    logic [7:0] pm_data;
    logic       slot_clock;
    logic       dsi_required;
    logic       lpvc_count;
    logic [2:0] port_number;
    logic [6:0] tc_map;
  } port_fields_t;

  typedef enum logic [1:0] {
    ST_START,
    ST_FETCH,
    ST_WAIT,
    ST_DONE
  } loader_state_t;

endpackage

/* rtl/word_fetch.sv */
`timescale 1ns/1ns
// Fetches one word from the configuration memory per start pulse.
module word_fetch
  import cfg_loader_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          start,
  input  wire logic [AW-1:0] addr,
  output logic      [AW-1:0] nv_addr,
  output logic               nv_req,
  input  wire logic [DW-1:0] nv_data,
  input  wire logic          nv_valid,
  output logic      [DW-1:0] word,
  output logic               done
);

  wire take = nv_req && nv_valid;

  // The request stands until the memory answers, so a slow memory only
  // stretches the load and never loses a word.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      nv_req  <= 1'b0;
      nv_addr <= '0;
      word    <= '0;
      done    <= 1'b0;
    end else begin
      done <= take;
      if (take) begin
        nv_req <= 1'b0;
        word   <= nv_data;
      end else if (start && !nv_req) begin
        nv_req  <= 1'b1;
        nv_addr <= addr;
      end
    end
  end

endmodule

/* rtl/cfg_word_loader.sv */
`timescale 1ns/1ns
`include "cfg_loader_cfg.svh"
module cfg_word_loader
  import cfg_loader_pkg::*;
#(
  parameter int NPORTS = 3,
  parameter int AW     = 8,
  parameter int DW     = 16
) (
  input  wire logic          CLOCK,
  input  wire logic          RESET_N,
  input  wire logic [10:0]   CFG_ADDR,
  input  wire logic [31:0]   CFG_WDATA,
  input  wire logic          CFG_WR,
  input  wire logic          CFG_RD,
  output logic      [31:0]   CFG_RDATA,
  output logic               CFG_READY,
  output logic      [AW-1:0] NV_ADDR,
  output logic               NV_REQ,
  input  wire logic [DW-1:0] NV_DATA,
  input  wire logic          NV_VALID,
  output port_fields_t [NPORTS-1:0] PORT_FIELDS
);

  if (NPORTS != 3 || AW != 8 || DW != 16) begin : g_bad_param
    $error("Loader serves exactly three ports and 8x16 memory words.");
  end

  loader_state_t state;
  loader_state_t next_state;
  logic [3:0]    idx;
  logic [3:0]    next_idx;
  logic          loaded;
  logic [DW-1:0] word;
  logic          fetch_done;
  port_fields_t  fields [NPORTS];
  port_fields_t  next_fields [NPORTS];

  // Word address for each load step.
  function automatic logic [AW-1:0] word_addr(input logic [3:0] i);
    case (i)
      4'h0:    word_addr = `WA_P2_LINK;
      4'h1:    word_addr = `WA_PM_CAP0;
      4'h2:    word_addr = `WA_PM_DATA0;
      4'h3:    word_addr = `WA_PM_CAP1;
      4'h4:    word_addr = `WA_PM_DATA1;
      4'h5:    word_addr = `WA_PM_CAP2;
      4'h6:    word_addr = `WA_PM_DATA2;
      default: word_addr = `WA_P0_MISC;
    endcase
  endfunction

  // Places the loaded fields of one port into the dword at an offset.
  function automatic logic [31:0] cfg_dword(input port_fields_t f,
                                            input logic [8:0]   ofs);
    logic [31:0] d;
    d = '0;
    case (ofs)
      `OFS_PM_CAP: begin
        d[`DST_AUX +: 3] = f.aux_current;
        d[`DST_D1]       = f.d1_support;
        d[`DST_D2]       = f.d2_support;
        d[`DST_PME +: 2] = f.pme_support;
        d[`DST_DSI]      = f.dsi_required;
      end
      `OFS_PM_CSR: begin
        d[`DST_NSR]         = f.no_soft_reset;
        d[`DST_PMDATA +: 8] = f.pm_data;
      end
      `OFS_LINK:     d[`DST_CMPL]       = f.compliance;
      `OFS_PHY_CNT:  d[`DST_DSEL +: 2]  = f.data_change_count_select;
      `OFS_PORT_NUM: d[`DST_PNUM +: 3]  = f.port_number;
      `OFS_SLOT:     d[`DST_SLOT]       = f.slot_clock;
      `OFS_LPVC:     d[`DST_LPVC]       = f.lpvc_count;
      `OFS_VC0_MAP:  d[`DST_TCMAP +: 7] = f.tc_map;
      default:       d = '0;
    endcase
    return d;
  endfunction

  // Register decode: the top two address bits pick the port.
  wire [1:0]  acc_port  = CFG_ADDR[10:9];
  wire [8:0]  acc_ofs   = CFG_ADDR[8:0];
  wire        ldr_sel   = acc_port == `LDR_PORT && acc_ofs == `OFS_LDR_CTRL;
  wire        busy      = state != ST_DONE;
  wire        reload    = CFG_WR && ldr_sel && CFG_WDATA[`LDR_RELOAD];
  wire        start     = state == ST_FETCH;
  wire [31:0] ldr_stat  = {30'h0, loaded, busy};
  wire [31:0] port_word = (acc_port == `LDR_PORT || !CFG_READY) ? 32'h0 :
                          cfg_dword(fields[acc_port], acc_ofs);
  wire [31:0] rd_word   = ldr_sel ? ldr_stat : port_word;

  assign CFG_READY = !busy;

  word_fetch #(
    .AW(AW),
    .DW(DW)
  ) u_fetch (
    .clock    (CLOCK),
    .reset_n  (RESET_N),
    .start    (start),
    .addr     (word_addr(idx)),
    .nv_addr  (NV_ADDR),
    .nv_req   (NV_REQ),
    .nv_data  (NV_DATA),
    .nv_valid (NV_VALID),
    .word     (word),
    .done     (fetch_done)
  );

  // Sequencer walks every word once after reset and on each reload.
  // A reload while busy is ignored, so a load is never cut short.
  always_comb begin
    next_state = state;
    next_idx   = idx;
    case (state)
      ST_START: begin
        next_idx   = 4'h0;
        next_state = ST_FETCH;
      end
      ST_FETCH: next_state = ST_WAIT;
      ST_WAIT: begin
        if (fetch_done) begin
          if (idx == `WORD_COUNT - 4'h1) begin
            next_state = ST_DONE;
          end else begin
            next_idx   = idx + 4'h1;
            next_state = ST_FETCH;
          end
        end
      end
      ST_DONE: begin
        if (reload) begin
          next_state = ST_START;
        end
      end
      default: next_state = ST_START;
    endcase
  end

  // Each step writes only the fields its word maps; all else holds.
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      next_fields[p] = fields[p];
    end
    if (fetch_done) begin
      case (idx)
        4'h0: begin
          next_fields[2].compliance = word[`SRC_CMPL];
          next_fields[2].data_change_count_select =
            word[`SRC_DSEL +: 2];
        end
        4'h1, 4'h3, 4'h5: begin
          next_fields[idx[2:1]].no_soft_reset = word[`SRC_NSR];
          next_fields[idx[2:1]].aux_current = word[`SRC_AUX +: 3];
          next_fields[idx[2:1]].d1_support  = word[`SRC_D1];
          next_fields[idx[2:1]].d2_support  = word[`SRC_D2];
          next_fields[idx[2:1]].pme_support = word[`SRC_PME +: 2];
        end
        4'h2, 4'h4, 4'h6: begin
          next_fields[idx[2:1] - 2'h1].pm_data =
            word[`SRC_PMDATA +: 8];
        end
        4'h7: begin
          next_fields[0].slot_clock   = word[`SRC_SLOT];
          next_fields[0].dsi_required = word[`SRC_DSI];
          next_fields[0].lpvc_count   = word[`SRC_LPVC];
          next_fields[0].port_number  = word[`SRC_PNUM +: 3];
          next_fields[0].tc_map       = word[`SRC_TCMAP +: 7];
        end
        default: next_fields[0] = fields[0];
      endcase
    end
  end

  // State, field and read data registers.
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state     <= ST_START;
      idx       <= 4'h0;
      loaded    <= 1'b0;
      CFG_RDATA <= 32'h0;
      for (int p = 0; p < NPORTS; p++) begin
        fields[p] <= '0;
      end
    end else begin
      state  <= next_state;
      idx    <= next_idx;
      loaded <= loaded || (state == ST_WAIT && next_state == ST_DONE);
      if (CFG_RD) begin
        CFG_RDATA <= rd_word;
      end
      for (int p = 0; p < NPORTS; p++) begin
        fields[p] <= next_fields[p];
      end
    end
  end

  for (genvar p = 0; p < NPORTS; p++) begin : g_out
    assign PORT_FIELDS[p] = fields[p];
  end

  // Checks of the load mapping and of the hidden window during loads.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  sequence s_apply(logic [3:0] i);
    fetch_done && idx == i;
  endsequence

  property p_hidden;
    CFG_RD && !CFG_READY && !ldr_sel |=> CFG_RDATA == 32'h0;
  endproperty
  a_hidden: assert property (p_hidden)
    else $error("Configuration read returned data during load.");

  property p_load_ends;
    NV_VALID && NV_REQ && idx == `WORD_COUNT - 4'h1 |=> ##1 CFG_READY;
  endproperty
  a_load_ends: assert property (p_load_ends)
    else $error("Loader not ready after its last word.");

  property p_cmpl_dsel;
    s_apply(4'h0) |=> fields[2].compliance == $past(word[`SRC_CMPL]) &&
      fields[2].data_change_count_select == $past(word[15:14]);
  endproperty
  a_cmpl_dsel: assert property (p_cmpl_dsel)
    else $error("Port 2 link fields not loaded.");

  property p_pm_cap;
    s_apply(4'h3) |=> fields[1].no_soft_reset == $past(word[0]) &&
      fields[1].aux_current == $past(word[3:1]);
  endproperty
  a_pm_cap: assert property (p_pm_cap)
    else $error("Port 1 capability fields not loaded.");

  property p_pm_dstate;
    s_apply(4'h5) |=> fields[2].d1_support == $past(word[4]) &&
      fields[2].d2_support == $past(word[5]) &&
      fields[2].pme_support == $past(word[7:6]);
  endproperty
  a_pm_dstate: assert property (p_pm_dstate)
    else $error("Port 2 power state support not loaded.");

  property p_pm_data;
    s_apply(4'h4) |=> fields[1].pm_data == $past(word[15:8]) &&
      $stable(fields[0].pm_data);
  endproperty
  a_pm_data: assert property (p_pm_data)
    else $error("Port 1 data byte misloaded.");

  property p_data_addr;
    $rose(NV_REQ) && idx == 4'h6 |-> NV_ADDR == 8'h55;
  endproperty
  a_data_addr: assert property (p_data_addr)
    else $error("Port 2 data word fetched from wrong address.");

  property p_misc;
    s_apply(4'h7) |=> fields[0].slot_clock == $past(word[1]) &&
      fields[0].dsi_required == $past(word[2]) &&
      fields[0].lpvc_count == $past(word[3]) &&
      fields[0].port_number == $past(word[6:4]) &&
      fields[0].tc_map == $past(word[15:9]);
  endproperty
  a_misc: assert property (p_misc)
    else $error("Port 0 miscellaneous fields not loaded.");

  property p_keep;
    fields[1].slot_clock == 1'b0 && fields[2].tc_map == 7'h00 &&
      fields[0].compliance == 1'b0;
  endproperty
  a_keep: assert property (p_keep)
    else $error("Unmapped field changed from its reset default.");

  // Fields move only on a loaded word, so nothing else can disturb them.
  property p_quiet;
    !fetch_done |=> $stable(fields[0]) && $stable(fields[1]) &&
      $stable(fields[2]);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("Fields changed without a loaded word.");

  // A pending word request keeps its address until the memory answers.
  property p_req_hold;
    NV_REQ && !NV_VALID |=> NV_REQ && $stable(NV_ADDR);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("Word request dropped or moved before its answer.");

endmodule

/* tb/nv_memory_model.sv */
`timescale 1ns/1ns
`include "cfg_loader_cfg.svh"
// Configuration memory that answers each request after a set delay.
module nv_memory_model (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [7:0]       nv_addr,
  input  wire logic             nv_req,
  input  wire logic [7:0][15:0] words,
  input  wire logic [3:0]       delay,
  output logic      [15:0]      nv_data,
  output logic                  nv_valid
);
  logic [3:0]  cnt;
  logic [15:0] word_at;

  // Word lookup; an address outside the map returns a changing pattern.
  always_comb begin
    case (nv_addr)
      `WA_P2_LINK:  word_at = words[0];
      `WA_PM_CAP0:  word_at = words[1];
      `WA_PM_DATA0: word_at = words[2];
      `WA_PM_CAP1:  word_at = words[3];
      `WA_PM_DATA1: word_at = words[4];
      `WA_PM_CAP2:  word_at = words[5];
      `WA_PM_DATA2: word_at = words[6];
      `WA_P0_MISC:  word_at = words[7];
      default:      word_at = ~nv_data;
    endcase
  end

  // Data flips outside the answer cycle, so a late sample never matches.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt      <= 4'h0;
      nv_valid <= 1'b0;
      nv_data  <= 16'hA5C3;
    end else if (nv_req && !nv_valid && cnt >= delay) begin
      cnt      <= 4'h0;
      nv_valid <= 1'b1;
      nv_data  <= word_at;
    end else begin
      cnt      <= (nv_req && !nv_valid) ? cnt + 4'h1 : 4'h0;
      nv_valid <= 1'b0;
      nv_data  <= ~nv_data;
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
`include "cfg_loader_cfg.svh"
// Loads random word sets, reloads them and reads every mapped dword back.
module testbench;
  import cfg_loader_pkg::*;
  logic             CLOCK;
  logic             RESET_N;
  logic [10:0]      CFG_ADDR;
  logic [31:0]      CFG_WDATA;
  logic             CFG_WR;
  logic             CFG_RD;
  logic [31:0]      CFG_RDATA;
  logic             CFG_READY;
  logic [7:0]       NV_ADDR;
  logic             NV_REQ;
  logic [15:0]      NV_DATA;
  logic             NV_VALID;
  port_fields_t [2:0] PORT_FIELDS;
  logic [7:0][15:0] words;
  logic [3:0]       delay;
  logic [31:0]      lfsr;
  logic [31:0]      d;
  int               errors;
  int               n_tests;

  cfg_word_loader dut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .CFG_ADDR(CFG_ADDR),
    .CFG_WDATA(CFG_WDATA), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
    .CFG_RDATA(CFG_RDATA), .CFG_READY(CFG_READY), .NV_ADDR(NV_ADDR),
    .NV_REQ(NV_REQ), .NV_DATA(NV_DATA), .NV_VALID(NV_VALID),
    .PORT_FIELDS(PORT_FIELDS)
  );

  nv_memory_model nv_mem (
    .clock(CLOCK), .reset_n(RESET_N), .nv_addr(NV_ADDR), .nv_req(NV_REQ),
    .words(words), .delay(delay), .nv_data(NV_DATA), .nv_valid(NV_VALID)
  );

  // Free-running bus clock.
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  function automatic logic [31:0] step(input logic [31:0] s);
    step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected dword from the current word set; unmapped bits stay zero.
  function automatic logic [31:0] exp_dw(input int p, input logic [8:0] ofs);
    logic [15:0] c;
    logic [15:0] a;
    logic [15:0] m;
    logic [15:0] l;
    c = words[1 + 2 * p];
    a = words[2 + 2 * p];
    m = words[7];
    l = words[0];
    case (ofs)
      `OFS_PM_CAP: exp_dw = {2'h0, c[7:6], 1'b0, c[5], c[4], c[3:1],
                             (p == 0) && m[2], 21'h0};
      `OFS_PM_CSR: exp_dw = {a[15:8], 20'h0, c[0], 3'h0};
      `OFS_LINK: exp_dw = (p == 2) ? {20'h0, l[13], 11'h0} : 32'h0;
      `OFS_PHY_CNT: exp_dw = (p == 2) ? {22'h0, l[15:14], 8'h0} : 32'h0;
      `OFS_PORT_NUM: exp_dw = (p == 0) ? {5'h0, m[6:4], 24'h0} : 32'h0;
      `OFS_SLOT: exp_dw = (p == 0) ? {3'h0, m[1], 28'h0} : 32'h0;
      `OFS_LPVC: exp_dw = (p == 0) ? {27'h0, m[3], 4'h0} : 32'h0;
      `OFS_VC0_MAP: exp_dw = (p == 0) ? {24'h0, m[15:9], 1'b0} : 32'h0;
      default: exp_dw = 32'h0;
    endcase
  endfunction

  // Expected loaded fields of one port, packed in the struct's field order.
  function automatic logic [31:0] exp_pf(input int p);
    logic [15:0] c;
    logic [15:0] a;
    logic [15:0] m;
    logic [15:0] l;
    c = words[1 + 2 * p];
    a = words[2 + 2 * p];
    m = (p == 0) ? words[7] : 16'h0000;
    l = (p == 2) ? words[0] : 16'h0000;
    exp_pf = {l[13], l[15:14], c[0], c[3:1], c[4], c[5], c[7:6], a[15:8],
              m[1], m[2], m[3], m[6:4], m[15:9]};
  endfunction

  task automatic complete_run;
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", name, e, g);
      errors++;
    end
  endtask

  // One read: strobe for a cycle, data taken in the cycle after.
  task automatic rd(input logic [1:0] p, input logic [8:0] ofs,
                    output logic [31:0] data);
    @(posedge CLOCK);
    CFG_RD   <= 1'b1;
    CFG_ADDR <= {p, ofs};
    @(posedge CLOCK);
    CFG_RD <= 1'b0;
    #1 data = CFG_RDATA;
  endtask

  task automatic wr(input logic [1:0] p, input logic [8:0] ofs,
                    input logic [31:0] data);
    @(posedge CLOCK);
    CFG_WR    <= 1'b1;
    CFG_ADDR  <= {p, ofs};
    CFG_WDATA <= data;
    @(posedge CLOCK);
    CFG_WR <= 1'b0;
  endtask

  task automatic cmp_ofs(input int p, input logic [8:0] ofs);
    logic [31:0] g;
    rd(p[1:0], ofs, g);
    chk($sformatf("dword p%0d at %h", p, ofs), exp_dw(p, ofs), g);
  endtask

  // A hung load ends the run rather than the simulator.
  task automatic wait_ready;
    int k;
    for (k = 0; k < 2000 && CFG_READY !== 1'b1; k++)
      @(posedge CLOCK);
    if (CFG_READY !== 1'b1) begin
      $display("[FAIL] ready expected 1 seen %b", CFG_READY);
      errors++;
      complete_run();
    end
  endtask

  task automatic check_all;
    for (int p = 0; p < 3; p++) begin
      cmp_ofs(p, `OFS_PM_CAP);
      cmp_ofs(p, `OFS_PM_CSR);
      cmp_ofs(p, `OFS_LINK);
      cmp_ofs(p, `OFS_PHY_CNT);
      cmp_ofs(p, `OFS_SLOT);
      cmp_ofs(p, `OFS_LPVC);
      cmp_ofs(p, `OFS_PORT_NUM);
      cmp_ofs(p, `OFS_VC0_MAP);
      cmp_ofs(p, 9'h048);
      chk($sformatf("fields p%0d", p), exp_pf(p), PORT_FIELDS[p]);
    end
    rd(`LDR_PORT, `OFS_LDR_CTRL, d);
    chk("loader status", 32'h00000002, d);
  endtask

  // First load with all ones and a slow memory, then zeros and random sets.
  initial begin
    RESET_N   = 1'b0;
    CFG_ADDR  = 11'h000;
    CFG_WDATA = 32'h00000000;
    CFG_WR    = 1'b0;
    CFG_RD    = 1'b0;
    errors    = 0;
    n_tests   = 0;
    lfsr      = 32'h4D2B2DDA;
    delay     = 4'h3;
    words     = {8{16'hFFFF}};
    repeat (20) @(posedge CLOCK);
    RESET_N <= 1'b1;
    rd(2'h0, `OFS_PM_CAP, d);
    chk("early read", 32'h00000000, d);
    rd(`LDR_PORT, `OFS_LDR_CTRL, d);
    chk("status in load", 32'h00000001, d);
    wait_ready();
    check_all();
    wr(2'h0, `OFS_PM_CAP, 32'hFFFFFFFF);
    cmp_ofs(0, `OFS_PM_CAP);
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 8; i++) begin
        lfsr = step(lfsr);
        words[i] <= (r == 0) ? 16'h0000 : lfsr[15:0];
      end
      delay <= (r == 0) ? 4'h0 : {2'h0, lfsr[17:16]};
      wr(`LDR_PORT, `OFS_LDR_CTRL, 32'h00000001);
      rd(2'h0, `OFS_PM_CSR, d);
      chk("reload read", 32'h00000000, d);
      rd(`LDR_PORT, `OFS_LDR_CTRL, d);
      chk("status in reload", 32'h00000003, d);
      wait_ready();
      check_all();
    end
    complete_run();
  end
endmodule
